// >>> include/subtract_consts.svh
`ifndef SUBTRACT_CONSTS_SVH
`define SUBTRACT_CONSTS_SVH

// register byte offsets
`define OFS_INSTR        8'h00
`define OFS_ACC          8'h04
`define OFS_BANK         8'h08
`define OFS_STATUS       8'h0C
`define OFS_FADDR        8'h10
`define OFS_FDATA        8'h14

// status field positions
`define BIT_C            0
`define BIT_DC           1
`define BIT_Z            2
`define BIT_OV           3
`define BIT_N            4
`define BIT_BUSY         5
`define BIT_BADOP        6

// opcode field positions and fixed upper bits
`define BIT_DEST         9
`define BIT_BANKSEL      8
`define BIT_ACCESS_HI    7
`define OPC_LIT          8'h08
`define OPC_FILE         6'h17
`define OPC_BORROW       6'h15

// access bank mapping
`define ACCESS_LO_BANK   4'h0
`define ACCESS_HI_BANK   4'hF

// reset values
`define RST_INSTR        16'h0000
`define RST_ACC          8'h00
`define RST_BANK         4'h0
`define RST_FLAGS        5'h00
`define RST_FADDR        12'h000

// bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// clocks in one instruction cycle
`define PHASE_COUNT      4

`endif

// >>> include/subtract_pkg.sv
package subtract_pkg;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_Q1   = 3'b001,
    PH_Q2   = 3'b010,
    PH_Q3   = 3'b011,
    PH_Q4   = 3'b100
  } phase_t;

  typedef enum logic [1:0] {
    OP_NONE   = 2'b00,
    OP_LIT    = 2'b01,
    OP_FILE   = 2'b10,
    OP_BORROW = 2'b11
  } op_t;

endpackage : subtract_pkg

// >>> verilog/phase_sequencer.sv
`timescale 1ns/1ns
module phase_sequencer (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            ce,
  // control
  input  wire logic            start,
  output subtract_pkg::phase_t phase,
  output logic                 busy
);

  subtract_pkg::phase_t phase_reg;
  subtract_pkg::phase_t phase_next;

  // one instruction cycle is four clocks, one per phase
  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      subtract_pkg::PH_IDLE: begin
        if (start) begin
          phase_next = subtract_pkg::PH_Q1;
        end
      end
      subtract_pkg::PH_Q1: phase_next = subtract_pkg::PH_Q2;
      subtract_pkg::PH_Q2: phase_next = subtract_pkg::PH_Q3;
      subtract_pkg::PH_Q3: phase_next = subtract_pkg::PH_Q4;
      subtract_pkg::PH_Q4: phase_next = subtract_pkg::PH_IDLE;
      default:             phase_next = subtract_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= subtract_pkg::PH_IDLE;
    end else if (ce) begin
      phase_reg <= phase_next;
    end
  end

  assign phase = phase_reg;
  assign busy  = (phase_reg != subtract_pkg::PH_IDLE);

  sequence s_go;
    (phase_reg == subtract_pkg::PH_IDLE) && start && ce;
  endsequence

  property p_four_phase;
    @(posedge clk) disable iff (!rst_b)
    s_go ##1 ce[*4] |=> (phase_reg == subtract_pkg::PH_IDLE) && $past(busy);
  endproperty
  a_four_phase: assert property (p_four_phase) else $error("cycle not four phases");

endmodule : phase_sequencer

// >>> verilog/sub_alu.sv
`timescale 1ns/1ns
module sub_alu (
  // operands
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  // result and flags
  output logic [7:0]      result,
  output logic            carry,
  output logic            digit_carry,
  output logic            zero,
  output logic            overflow,
  output logic            negative
);

  logic [8:0] sum;
  logic [4:0] low;

  // a - b done as a + ~b + cin, so carry out is the inverted borrow
  assign sum         = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
  assign low         = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
  assign result      = sum[7:0];
  assign carry       = sum[8];
  assign digit_carry = low[4];
  assign zero        = (sum[7:0] == 8'h00);
  assign overflow    = (a[7] ^ b[7]) & (sum[7] ^ a[7]);
  assign negative    = sum[7];

endmodule : sub_alu

// >>> verilog/subtract_datapath.sv
// How it works
// - the literal subtract takes the low opcode byte minus the accumulator.
// - the literal subtract writes only the accumulator, never a file register.
// - the literal subtract decodes, reads k, computes and writes in four phases.
// - the file subtract takes the addressed file register minus the accumulator.
// - with the destination bit clear the result goes to the accumulator only.
// - with the destination bit set the result goes back to the file register.
// - with the bank bit clear the access bank is used and the bank register ignored.
// - with the bank bit set the bank register picks the bank of the operand.
// - a file subtract runs decode, read, compute, write within one cycle.
// - carry is an inverted borrow, set for zero or positive differences.
// - subtract with borrow takes acc minus file minus inverted carry, same steering.
`timescale 1ns/1ns
`include "subtract_consts.svh"
module subtract_datapath (
  // clock, reset, enable
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  input  wire logic        CE,
  // write address
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  // write data
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  // write response
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // read address
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  // read data
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);

  // bus slave state
  logic                 aw_held_reg;
  logic                 w_held_reg;
  logic [7:0]           awaddr_reg;
  logic [31:0]          wdata_reg;
  logic [3:0]           wstrb_reg;
  logic                 bvalid_reg;
  logic [1:0]           bresp_reg;
  logic                 rvalid_reg;
  logic [31:0]          rdata_reg;
  logic [1:0]           rresp_reg;
  // programmer state
  logic [15:0]          instr_reg;
  logic [7:0]           acc_reg;
  logic [3:0]           bank_reg;
  logic [4:0]           flags_reg;
  logic                 bad_op_reg;
  logic [11:0]          faddr_reg;
  logic [7:0]           file_mem [0:4095];
  // execution state
  subtract_pkg::op_t    op_reg;
  logic [7:0]           operand_reg;
  logic [7:0]           result_reg;
  logic [4:0]           newflags_reg;
  subtract_pkg::phase_t phase;
  logic                 busy;

  function automatic subtract_pkg::op_t op_of(input logic [15:0] code);
    if (code[15:8] == `OPC_LIT) begin
      return subtract_pkg::OP_LIT;
    end else if (code[15:10] == `OPC_FILE) begin
      return subtract_pkg::OP_FILE;
    end else if (code[15:10] == `OPC_BORROW) begin
      return subtract_pkg::OP_BORROW;
    end
    return subtract_pkg::OP_NONE;
  endfunction : op_of

  // bus handshake and write decode
  wire aw_take    = AWVALID && AWREADY;
  wire w_take     = WVALID && WREADY;
  wire ar_take    = ARVALID && ARREADY;
  wire do_write   = CE && aw_held_reg && w_held_reg && !bvalid_reg;
  wire sel_instr  = (awaddr_reg == `OFS_INSTR);
  wire sel_acc    = (awaddr_reg == `OFS_ACC);
  wire sel_bank   = (awaddr_reg == `OFS_BANK);
  wire sel_status = (awaddr_reg == `OFS_STATUS);
  wire sel_faddr  = (awaddr_reg == `OFS_FADDR);
  wire sel_fdata  = (awaddr_reg == `OFS_FDATA);
  wire wr_hit     = sel_instr | sel_acc | sel_bank | sel_status | sel_faddr | sel_fdata;
  // every write is refused while busy, so software never races the phase pipeline
  wire write_ok   = do_write && wr_hit && !busy;
  wire lane0      = wstrb_reg[0];
  wire lane1      = wstrb_reg[1];

  wire [15:0] instr_merged = {lane1 ? wdata_reg[15:8] : instr_reg[15:8],
                              lane0 ? wdata_reg[7:0]  : instr_reg[7:0]};
  wire subtract_pkg::op_t op_new = op_of(instr_merged);
  wire start      = write_ok && sel_instr && (op_new != subtract_pkg::OP_NONE);
  wire bad_op_set = write_ok && sel_instr && (op_new == subtract_pkg::OP_NONE);
  wire bad_op_clr = write_ok && sel_status && lane0 && wdata_reg[`BIT_BADOP];

  // phase decode
  wire in_q1      = (phase == subtract_pkg::PH_Q1);
  wire in_q2      = (phase == subtract_pkg::PH_Q2);
  wire in_q3      = (phase == subtract_pkg::PH_Q3);
  wire in_q4      = (phase == subtract_pkg::PH_Q4);
  wire op_lit     = (op_reg == subtract_pkg::OP_LIT);
  wire op_borrow  = (op_reg == subtract_pkg::OP_BORROW);
  wire op_filety  = (op_reg == subtract_pkg::OP_FILE) || op_borrow;
  wire dest_file  = instr_reg[`BIT_DEST];
  wire [7:0] lit_k = instr_reg[7:0];

  // operand address: access bank splits low half to bank 0, high half to the top bank
  wire [3:0] access_bank = instr_reg[`BIT_ACCESS_HI] ? `ACCESS_HI_BANK : `ACCESS_LO_BANK;
  wire [3:0] eff_bank    = instr_reg[`BIT_BANKSEL] ? bank_reg : access_bank;
  wire [11:0] eff_addr   = {eff_bank, lit_k};

  // alu steering: borrow form swaps operands and feeds the stored carry
  wire [7:0] alu_a   = op_borrow ? acc_reg : operand_reg;
  wire [7:0] alu_b   = op_borrow ? operand_reg : acc_reg;
  wire       alu_cin = op_borrow ? flags_reg[`BIT_C] : 1'b1;
  logic [7:0] alu_result;
  logic       alu_c;
  logic       alu_dc;
  logic       alu_z;
  logic       alu_ov;
  logic       alu_n;

  // destination steering
  wire exec_wb     = in_q4 && (op_reg != subtract_pkg::OP_NONE);
  wire exec_acc_we = exec_wb && (op_lit || !dest_file);
  wire exec_mem_we = exec_wb && op_filety && dest_file;
  wire sw_mem_we   = write_ok && sel_fdata && lane0;
  wire mem_we      = exec_mem_we || sw_mem_we;
  wire [11:0] mem_waddr = exec_mem_we ? eff_addr : faddr_reg;
  wire [7:0]  mem_wdata = exec_mem_we ? result_reg : wdata_reg[7:0];

  wire [7:0] acc_next = exec_acc_we ? result_reg :
                        (write_ok && sel_acc && lane0) ? wdata_reg[7:0] : acc_reg;
  wire [4:0] flags_next = exec_wb ? newflags_reg :
                          (write_ok && sel_status && lane0) ? wdata_reg[4:0] : flags_reg;
  wire [7:0] operand_next = op_lit ? lit_k : file_mem[eff_addr];

  // read decode
  wire [31:0] status_word = {25'h0000000, bad_op_reg, busy, flags_reg};
  wire rd_hit = (ARADDR == `OFS_INSTR) || (ARADDR == `OFS_ACC) || (ARADDR == `OFS_BANK) ||
                (ARADDR == `OFS_STATUS) || (ARADDR == `OFS_FADDR) || (ARADDR == `OFS_FDATA);
  wire [31:0] rd_word =
    (ARADDR == `OFS_INSTR)  ? {16'h0000, instr_reg} :
    (ARADDR == `OFS_ACC)    ? {24'h000000, acc_reg} :
    (ARADDR == `OFS_BANK)   ? {28'h0000000, bank_reg} :
    (ARADDR == `OFS_STATUS) ? status_word :
    (ARADDR == `OFS_FADDR)  ? {20'h00000, faddr_reg} :
    (ARADDR == `OFS_FDATA)  ? {24'h000000, file_mem[faddr_reg]} : 32'h00000000;

  assign AWREADY = CE && !aw_held_reg;
  assign WREADY  = CE && !w_held_reg;
  assign ARREADY = CE && !rvalid_reg;
  assign BVALID  = bvalid_reg;
  assign BRESP   = bresp_reg;
  assign RVALID  = rvalid_reg;
  assign RDATA   = rdata_reg;
  assign RRESP   = rresp_reg;

  phase_sequencer u_seq (
    .clk   (CLOCK),
    .rst_b (RST_B),
    .ce    (CE),
    .start (start),
    .phase (phase),
    .busy  (busy)
  );

  sub_alu u_alu (
    .a           (alu_a),
    .b           (alu_b),
    .cin         (alu_cin),
    .result      (alu_result),
    .carry       (alu_c),
    .digit_carry (alu_dc),
    .zero        (alu_z),
    .overflow    (alu_ov),
    .negative    (alu_n)
  );

  // write channel capture, either order
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
    end else if (CE) begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= AWADDR;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= WDATA;
        wstrb_reg  <= WSTRB;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // responses
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `RESP_OKAY;
    end else if (CE) begin
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= write_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (BREADY) begin
        bvalid_reg <= 1'b0;
      end
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_word;
        rresp_reg  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // programmer registers
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      instr_reg  <= `RST_INSTR;
      acc_reg    <= `RST_ACC;
      bank_reg   <= `RST_BANK;
      flags_reg  <= `RST_FLAGS;
      faddr_reg  <= `RST_FADDR;
      bad_op_reg <= 1'b0;
    end else if (CE) begin
      acc_reg   <= acc_next;
      flags_reg <= flags_next;
      if (write_ok && sel_instr) begin
        instr_reg <= instr_merged;
      end
      if (write_ok && sel_bank && lane0) begin
        bank_reg <= wdata_reg[3:0];
      end
      if (write_ok && sel_faddr) begin
        faddr_reg <= {lane1 ? wdata_reg[11:8] : faddr_reg[11:8],
                      lane0 ? wdata_reg[7:0]  : faddr_reg[7:0]};
      end
      // a new fault wins over a clear in the same cycle
      bad_op_reg <= bad_op_set || (bad_op_reg && !bad_op_clr);
    end
  end

  // decode, read, compute
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      op_reg       <= subtract_pkg::OP_NONE;
      operand_reg  <= 8'h00;
      result_reg   <= 8'h00;
      newflags_reg <= 5'h00;
    end else if (CE) begin
      if (in_q1) begin
        op_reg <= op_of(instr_reg);
      end
      if (in_q2) begin
        operand_reg <= operand_next;
      end
      if (in_q3) begin
        result_reg   <= alu_result;
        newflags_reg <= {alu_n, alu_ov, alu_z, alu_dc, alu_c};
      end
    end
  end

  // file registers hold data only, so they carry no reset
  always_ff @(posedge CLOCK) begin
    if (CE && mem_we) begin
      file_mem[mem_waddr] <= mem_wdata;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  wire [7:0] file_minus_acc = operand_reg - acc_reg;
  wire [7:0] swb_expect     = acc_reg - operand_reg - {7'h00, !flags_reg[`BIT_C]};

  sequence s_lit_read;
    in_q2 && op_lit && CE;
  endsequence

  sequence s_compute_write;
    (in_q3 && CE) ##1 (in_q4 && CE);
  endsequence

  property p_lit_cycle;
    s_lit_read ##1 s_compute_write |=> acc_reg == $past(lit_k, 3) - $past(acc_reg, 3);
  endproperty
  a_lit_cycle: assert property (p_lit_cycle) else $error("literal result wrong");

  property p_lit_acc;
    (in_q4 && op_lit && CE) |=> acc_reg == $past(result_reg);
  endproperty
  a_lit_acc: assert property (p_lit_acc) else $error("literal not in acc");

  property p_lit_no_mem;
    (in_q4 && op_lit) |-> !mem_we;
  endproperty
  a_lit_no_mem: assert property (p_lit_no_mem) else $error("literal wrote file");

  property p_file_sub;
    (in_q3 && (op_reg == subtract_pkg::OP_FILE)) |-> alu_result == file_minus_acc;
  endproperty
  a_file_sub: assert property (p_file_sub) else $error("file minus acc wrong");

  property p_dest_acc;
    (in_q4 && CE && op_filety && !dest_file) |-> !mem_we ##1 acc_reg == $past(result_reg);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("acc destination wrong");

  property p_dest_file;
    (in_q4 && CE && op_filety && dest_file) |->
      (mem_we && mem_waddr == eff_addr && mem_wdata == result_reg) ##1 $stable(acc_reg);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file destination wrong");

  // checks the operand actually fetched, not the address wire that produced it
  property p_access;
    (in_q3 && op_filety && !instr_reg[`BIT_BANKSEL]) |->
      operand_reg == file_mem[{(instr_reg[7] ? `ACCESS_HI_BANK : `ACCESS_LO_BANK),
                               instr_reg[7:0]}];
  endproperty
  a_access: assert property (p_access) else $error("access bank wrong");

  property p_banked;
    (in_q3 && op_filety && instr_reg[`BIT_BANKSEL]) |->
      operand_reg == file_mem[{bank_reg, instr_reg[7:0]}];
  endproperty
  a_banked: assert property (p_banked) else $error("bank select ignored");

  property p_file_cycle;
    (start && CE && op_new != subtract_pkg::OP_LIT) ##1 CE[*4] |=> !busy && $past(in_q4);
  endproperty
  a_file_cycle: assert property (p_file_cycle) else $error("file op not one cycle");

  property p_borrow_flag;
    (in_q3 && op_reg != subtract_pkg::OP_NONE) |->
      alu_c == ({1'b0, alu_a} >= ({1'b0, alu_b} + {8'h00, !alu_cin}));
  endproperty
  a_borrow_flag: assert property (p_borrow_flag) else $error("carry not inverted borrow");

  property p_swb;
    (in_q3 && op_borrow) |-> alu_result == swb_expect;
  endproperty
  a_swb: assert property (p_swb) else $error("borrow subtract wrong");

  property p_zero;
    (exec_wb && CE) |=> flags_reg[`BIT_Z] == ($past(result_reg) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule : subtract_datapath

// >>> verif/testbench.sv
`timescale 1ns/1ns
`include "subtract_consts.svh"
module testbench;
  // bus drive and observation
  logic        clock   = 1'b0;
  logic        rst_b   = 1'b0;
  logic        ce      = 1'b1;
  logic [7:0]  awaddr  = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        wvalid  = 1'b0;
  logic [7:0]  araddr  = 8'h00;
  logic        arvalid = 1'b0;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  int          err_total    = 0;
  int          total_checks = 0;
  // literal cases, ordered from plain to signed-overflow corners
  localparam logic [7:0] LIT_K [0:4] = '{8'h02, 8'h02, 8'h02, 8'h7F, 8'h80};
  localparam logic [7:0] LIT_A [0:4] = '{8'h01, 8'h02, 8'h03, 8'hFF, 8'h01};

  always #25 clock = ~clock;

  // ready lines held high: the master always accepts answers at once
  subtract_datapath subtract_datapath_inst (
    .CLOCK(clock), .RST_B(rst_b), .CE(ce),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(1'b1),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(1'b1)
  );

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clock);
      if (!ad && awready) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (!wd && wready) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end while (!(ad && wd));
    do @(posedge clock); while (!bvalid);
    chk(32'(bresp), 32'(er));
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock); while (!rvalid);
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask : rd

  // waits out one instruction cycle; results must be visible afterwards
  task exec(input logic [15:0] op);
    wr(`OFS_INSTR, {16'h0000, op}, `RESP_OKAY);
    repeat (`PHASE_COUNT) @(posedge clock);
  endtask : exec

  // reference a - b - !cin with flags packed {N,OV,Z,DC,C} above the result
  function automatic logic [12:0] model(input logic [7:0] a, b, input logic cin);
    logic [8:0] d;
    logic [4:0] n;
    logic       ov;
    d  = {1'b0, a} - {1'b0, b} - {8'h00, ~cin};
    n  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin};
    ov = (a[7] != b[7]) && (d[7] != a[7]);
    return {d[7], ov, d[7:0] == 8'h00, ~n[4], ~d[8], d[7:0]};
  endfunction : model

  task file_op(input logic [5:0] opc, input logic [7:0] f, input logic a, dd,
               input logic [11:0] ph, input logic [7:0] rv, av, input logic cin);
    logic [12:0] m;
    m = (opc == `OPC_FILE) ? model(rv, av, 1'b1) : model(av, rv, cin);
    wr(`OFS_FADDR, {20'h00000, ph}, `RESP_OKAY);
    wr(`OFS_FDATA, {24'h000000, rv}, `RESP_OKAY);
    wr(`OFS_ACC, {24'h000000, av}, `RESP_OKAY);
    wr(`OFS_STATUS, {31'h0000_0000, cin}, `RESP_OKAY);
    exec({opc, dd, a, f});
    rd(`OFS_ACC, {24'h000000, dd ? av : m[7:0]}, `RESP_OKAY);
    rd(`OFS_FDATA, {24'h000000, dd ? m[7:0] : rv}, `RESP_OKAY);
    rd(`OFS_STATUS, {27'h0000000, m[12:8]}, `RESP_OKAY);
  endtask : file_op

  task t_reset;
    rd(`OFS_INSTR, 32'h0000_0000, `RESP_OKAY);
    rd(`OFS_ACC, 32'h0000_0000, `RESP_OKAY);
    rd(`OFS_BANK, 32'h0000_0000, `RESP_OKAY);
    rd(`OFS_STATUS, 32'h0000_0000, `RESP_OKAY);
    rd(8'h18, 32'h0000_0000, `RESP_SLVERR);
    wr(8'h1C, 32'h0000_00FF, `RESP_SLVERR);
    rd(`OFS_ACC, 32'h0000_0000, `RESP_OKAY);
    $display("test reset done");
  endtask : t_reset

  // a file cell at the literal's own address must survive every literal op
  task t_literal;
    logic [12:0] m;
    wr(`OFS_FADDR, 32'h0000_0002, `RESP_OKAY);
    wr(`OFS_FDATA, 32'h0000_005A, `RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      m = model(LIT_K[i], LIT_A[i], 1'b1);
      wr(`OFS_ACC, {24'h000000, LIT_A[i]}, `RESP_OKAY);
      wr(`OFS_STATUS, 32'h0000_0000, `RESP_OKAY);
      exec({`OPC_LIT, LIT_K[i]});
      rd(`OFS_ACC, {24'h000000, m[7:0]}, `RESP_OKAY);
      rd(`OFS_STATUS, {27'h0000000, m[12:8]}, `RESP_OKAY);
    end
    rd(`OFS_FDATA, 32'h0000_005A, `RESP_OKAY);
    $display("test literal done");
  endtask : t_literal

  // decoys sit where a wrong bank choice would land
  task t_file;
    wr(`OFS_FADDR, 32'h0000_0303, `RESP_OKAY);
    wr(`OFS_FDATA, 32'h0000_00AA, `RESP_OKAY);
    wr(`OFS_FADDR, 32'h0000_0010, `RESP_OKAY);
    wr(`OFS_FDATA, 32'h0000_0077, `RESP_OKAY);
    wr(`OFS_BANK, 32'h0000_0003, `RESP_OKAY);
    file_op(`OPC_FILE, 8'h03, 1'b0, 1'b0, 12'h003, 8'h03, 8'h02, 1'b0);
    file_op(`OPC_FILE, 8'h03, 1'b0, 1'b1, 12'h003, 8'h01, 8'h02, 1'b1);
    file_op(`OPC_FILE, 8'h85, 1'b0, 1'b0, 12'hF85, 8'h40, 8'h10, 1'b0);
    file_op(`OPC_FILE, 8'h10, 1'b1, 1'b1, 12'h310, 8'h20, 8'h20, 1'b0);
    wr(`OFS_FADDR, 32'h0000_0303, `RESP_OKAY);
    rd(`OFS_FDATA, 32'h0000_00AA, `RESP_OKAY);
    wr(`OFS_FADDR, 32'h0000_0010, `RESP_OKAY);
    rd(`OFS_FDATA, 32'h0000_0077, `RESP_OKAY);
    $display("test file done");
  endtask : t_file

  task t_borrow;
    file_op(`OPC_BORROW, 8'h03, 1'b0, 1'b1, 12'h003, 8'h03, 8'h02, 1'b1);
    file_op(`OPC_BORROW, 8'h04, 1'b0, 1'b0, 12'h004, 8'h02, 8'h03, 1'b1);
    file_op(`OPC_BORROW, 8'h05, 1'b0, 1'b1, 12'h005, 8'h01, 8'h02, 1'b0);
    file_op(`OPC_BORROW, 8'h20, 1'b1, 1'b0, 12'h320, 8'h10, 8'h05, 1'b0);
    $display("test borrow done");
  endtask : t_borrow

  // second opcode lands mid-instruction and must be turned away untouched
  task t_busy;
    wr(`OFS_ACC, 32'h0000_0001, `RESP_OKAY);
    wr(`OFS_INSTR, 32'h0000_0805, `RESP_OKAY);
    wr(`OFS_INSTR, 32'h0000_0800, `RESP_SLVERR);
    // a core frozen for 3 clocks after the instruction ends must still hold its result once enabled again
    ce <= 1'b0;
    repeat (3) @(posedge clock);
    ce <= 1'b1;
    repeat (`PHASE_COUNT) @(posedge clock);
    rd(`OFS_ACC, 32'h0000_0004, `RESP_OKAY);
    rd(`OFS_INSTR, 32'h0000_0805, `RESP_OKAY);
    $display("test busy done");
  endtask : t_busy

  task wrap_up;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    t_reset;
    t_literal;
    t_file;
    t_borrow;
    t_busy;
    wrap_up;
  end

  // the whole sequence needs a few hundred cycles; this is ample margin
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    wrap_up;
  end
endmodule : testbench
